// >>> hdl/stack_exec_consts.vh
// Constants for the stack push/pop execution block.
// Assumes inclusion by bare name from design files under hdl/.
`ifndef STACK_EXEC_CONSTS_VH
`define STACK_EXEC_CONSTS_VH

`define OPC_PUSH         8'hc0
`define OPC_POP          8'hd0
`define STACK_PTR_RESET       8'h07
`define STACK_PTR_DIRECT_ADDR 8'h81
`define FLAGS_DIRECT_ADDR     8'hd0
`define CYCLES_PER_INSN       2'h2

`endif

// >>> hdl/stack_ram.v
// Internal data memory of 256 bytes: one write port, one registered read port.
// Assumes a single clock; read data appear one edge after the address.
`timescale 1ns/1ps
module stack_ram (
    input  wire       clk_i,
    input  wire       wr_en_i,
    input  wire [7:0] wr_addr_i,
    input  wire [7:0] wr_data_i,
    input  wire [7:0] rd_addr_i,
    output reg  [7:0] rd_data_o
);

    reg [7:0] mem [0:255];

    ////////////////////////////////////////////////////////////////////////////
    // Write and registered read
    always @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end

endmodule

// >>> hdl/stack_push_pop_exec.v
// Execution of the push and pop stack instructions of an 8-bit core.
// Assumes the fetch unit presents opcode and second byte with a one-cycle start
// strobe, and that the direct space is reached through a simple read/write port
// whose read data return one cycle after the address.
`timescale 1ns/1ps
`include "stack_exec_consts.vh"
module stack_push_pop_exec (
    input  wire       clk_i,
    input  wire       sys_rst_i,
    input  wire       start_i,
    input  wire [7:0] opcode_i,
    input  wire [7:0] operand_i,
    input  wire [7:0] dir_rd_data_i,
    output wire [7:0] dir_rd_addr_o,
    output reg        dir_wr_en_o,
    output reg  [7:0] dir_wr_addr_o,
    output reg  [7:0] dir_wr_data_o,
    output wire       busy_o,
    output reg        done_o,
    output reg        illegal_o,
    output wire [7:0] stack_top_pointer_o
);

    localparam ST_IDLE = 2'h0;
    localparam ST_C1   = 2'h1;
    localparam ST_C2   = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle plan of one accepted instruction
    // Cycle 0: start seen in idle; instruction kind and address byte latched
    // Cycle 1: pop reads the stack at the old pointer; push presents its
    //          direct source address to the outside read port
    // Edge 1:  pointer moves by one, down for pop, up for push
    // Cycle 2: pop holds its stack byte; push holds its source byte and
    //          writes it into the stack at the already moved pointer
    // Edge 2:  pop into the pointer loads the popped byte over the pointer;
    //          every pop registers its direct write
    // Cycle 3: done pulse and pop write strobe; next start may be given
    //
    // Hazard: the stack read of a pop must use the old pointer, so the read
    // address is the pointer register itself, never its next value.
    // Hazard: a pop into the flag register reaches it through the direct
    // port only; this block keeps no flags and never alters them itself.
    // Limitation: starts while busy are dropped, not queued; the fetch side
    // must wait for busy low.
    // Limitation: the stack memory is not cleared by reset, so a pop from
    // an unwritten location returns whatever the memory holds.
    // Limitation: a pop into the pointer still issues the direct write to
    // the pointer's own address; the outside port must tolerate it.

    reg  [1:0] state_reg;
    reg  [1:0] state_next;
    reg        is_pop_reg;
    reg  [7:0] addr_reg;
    reg  [7:0] stack_top_pointer_reg;
    reg  [7:0] stack_top_pointer_next;
    reg        ram_wr_en;
    reg  [7:0] ram_wr_addr;
    reg  [7:0] ram_wr_data;
    reg  [7:0] ram_rd_addr;
    wire [7:0] ram_rd_data;
    wire       is_push_op;
    wire       is_pop_op;
    wire       in_idle;
    wire       in_first;
    wire       in_second;
    wire       take_start;
    wire       pop_to_pointer;
    wire       pop_writes_now;

    ////////////////////////////////////////////////////////////////////////////
    // Opcode decode
    assign is_push_op          = (opcode_i == `OPC_PUSH);
    assign is_pop_op           = (opcode_i == `OPC_POP);
    // State views shared by the control and output registers
    assign in_idle             = (state_reg == ST_IDLE);
    assign in_first            = (state_reg == ST_C1);
    assign in_second           = (state_reg == ST_C2);
    // A start is taken only in idle; starts while busy are ignored
    assign take_start          = in_idle && start_i;
    // Pop whose destination is the pointer itself
    assign pop_to_pointer      = is_pop_reg && (addr_reg == `STACK_PTR_DIRECT_ADDR);
    // Pop stores its byte in the second cycle, after the pointer update
    assign pop_writes_now      = in_second && is_pop_reg;
    assign busy_o              = !in_idle;
    assign stack_top_pointer_o = stack_top_pointer_reg;
    // Push fetches its direct source in cycle 1; read data arrive in cycle 2
    assign dir_rd_addr_o       = addr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Internal stack memory
    stack_ram u_ram (
        .clk_i     (clk_i),
        .wr_en_i   (ram_wr_en),
        .wr_addr_i (ram_wr_addr),
        .wr_data_i (ram_wr_data),
        .rd_addr_i (ram_rd_addr),
        .rd_data_o (ram_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state, pointer and memory control
    always @* begin
        state_next             = state_reg;
        stack_top_pointer_next = stack_top_pointer_reg;
        ram_wr_en              = 1'b0;
        ram_wr_addr            = stack_top_pointer_reg;
        ram_wr_data            = dir_rd_data_i;
        ram_rd_addr            = stack_top_pointer_reg;
        case (state_reg)
            // Wait for a start carrying a known opcode
            ST_IDLE: begin
                if (take_start && (is_push_op || is_pop_op)) begin
                    state_next = ST_C1;
                end
            end
            // Pointer moves at end of first cycle; RAM read already issued
            ST_C1: begin
                if (is_pop_reg) begin
                    stack_top_pointer_next = stack_top_pointer_reg - 8'h01;
                end else begin
                    stack_top_pointer_next = stack_top_pointer_reg + 8'h01;
                end
                state_next = ST_C2;
            end
            // Push writes at the moved pointer; pop into pointer overwrites it
            ST_C2: begin
                if (!is_pop_reg) begin
                    ram_wr_en   = 1'b1;
                    ram_wr_addr = stack_top_pointer_reg;
                end else if (pop_to_pointer) begin
                    stack_top_pointer_next = ram_rd_data;
                end
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State and pointer registers
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_reg             <= ST_IDLE;
            stack_top_pointer_reg <= `STACK_PTR_RESET;
        end else begin
            state_reg             <= state_next;
            stack_top_pointer_reg <= stack_top_pointer_next;
        end
    end

    // Latched instruction kind and address byte
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            is_pop_reg <= 1'b0;
            addr_reg   <= 8'h00;
        end else if (take_start) begin
            is_pop_reg <= is_pop_op;
            addr_reg   <= operand_i;
        end
    end

    // Completion pulse after the second cycle, refusal pulse for bad opcodes
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            done_o    <= 1'b0;
            illegal_o <= 1'b0;
        end else begin
            done_o    <= in_second;
            illegal_o <= take_start && !is_push_op && !is_pop_op;
        end
    end

    // Direct write of the popped byte; flags only change if the flag
    // register is itself the destination, push never writes here
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            dir_wr_en_o   <= 1'b0;
            dir_wr_addr_o <= 8'h00;
            dir_wr_data_o <= 8'h00;
        end else begin
            dir_wr_en_o <= pop_writes_now;
            if (pop_writes_now) begin
                dir_wr_addr_o <= addr_reg;
                dir_wr_data_o <= ram_rd_data;
            end
        end
    end

endmodule

// >>> tb/stack_exec_sva.sv
// Port checker for the stack push/pop execution block.
// Assumes a bind from the bench top onto the design's ports.
`timescale 1ns/1ps
`include "stack_exec_consts.vh"
module stack_exec_sva (
    input wire       clk_i, sys_rst_i, start_i, busy_o, done_o, illegal_o, dir_wr_en_o,
    input wire [7:0] opcode_i, operand_i, dir_rd_addr_o, dir_wr_addr_o, dir_wr_data_o,
    input wire [7:0] stack_top_pointer_o
);
    // Accepted starts by kind, pointer neighbours
    wire       psh = start_i && !busy_o && opcode_i == `OPC_PUSH;
    wire       pop = start_i && !busy_o && opcode_i == `OPC_POP;
    wire       bad = start_i && !busy_o && !psh && !pop;
    wire       tosp = operand_i == `STACK_PTR_DIRECT_ADDR;
    wire [7:0] spn = stack_top_pointer_o + 8'h01;
    wire [7:0] spp = stack_top_pointer_o - 8'h01;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_push_len: assert property (psh |=> busy_o ##1 busy_o ##1 !busy_o ##[0:1] done_o)
        else $error("push length");
    a_pop_len: assert property (pop |=> busy_o ##1 busy_o ##1 !busy_o ##[0:1] done_o)
        else $error("pop length");
    a_push_inc: assert property (psh |-> ##2 stack_top_pointer_o == $past(spn, 2))
        else $error("push pointer");
    a_pop_dec: assert property (pop && !tosp |-> ##2 stack_top_pointer_o == $past(spp, 2))
        else $error("pop pointer");
    a_pop_write: assert property (dir_wr_en_o |-> done_o && dir_wr_addr_o == dir_rd_addr_o)
        else $error("pop write");
    a_push_nowr: assert property (psh |=> !dir_wr_en_o [*3])
        else $error("push wrote");
    a_pop_ptr: assert property (pop && tosp |=> ##[1:2] (done_o && stack_top_pointer_o == dir_wr_data_o))
        else $error("pop to pointer");
    a_bad_quiet: assert property (bad |=> !busy_o && $stable(stack_top_pointer_o) ##[0:1] illegal_o)
        else $error("illegal opcode");
    c_pop: cover property (done_o && dir_wr_en_o);
    c_push: cover property (done_o && !dir_wr_en_o);
    c_bad: cover property (illegal_o);
endmodule

// >>> tb/stack_push_pop_exec_bench.sv
// Self-checking bench for the stack push/pop execution block.
// Assumes design files under hdl/ and the port checker in tb/.
`timescale 1ns/1ps
`include "stack_exec_consts.vh"
module stack_push_pop_exec_bench;
    reg         clk_i = 1'b0, sys_rst_i = 1'b1, start_i = 1'b0;
    reg  [7:0]  opcode_i = 8'h00, operand_i = 8'h00, dir_rd_data_i = 8'h00, key, ptr, v;
    wire [7:0]  dir_rd_addr_o, dir_wr_addr_o, dir_wr_data_o, stack_top_pointer_o;
    wire        dir_wr_en_o, busy_o, done_o, illegal_o;
    reg  [7:0]  ram [0:255];
    reg  [25:0] exp_q [$];
    integer     fails = 0, tests_run = 0, i, n;
    always #25 clk_i = ~clk_i;
    stack_push_pop_exec i_stack_push_pop_exec (.*);
    // Direct space: registered read, contents scrambled by a random key
    always @(posedge clk_i) dir_rd_data_i <= dir_rd_addr_o ^ key;
    task chk(input [25:0] got, input [25:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", tests_run, fails);
            if (fails == 0 && tests_run > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    // Result watcher: oldest note against the outputs
    always @(negedge clk_i)
        if (done_o === 1'b1 || illegal_o === 1'b1) begin
            if (exp_q.size() == 0) chk(26'h3ffffff, 26'h0000000);
            else chk({illegal_o, dir_wr_en_o, dir_wr_en_o ? {dir_wr_addr_o, dir_wr_data_o}
                : 16'h0000, stack_top_pointer_o}, exp_q.pop_front());
        end
    // One instruction with its expected result; dbl repeats start while busy
    task run(input [7:0] op, input [7:0] a, input dbl);
        begin
            @(posedge clk_i);
            start_i <= 1'b1;
            opcode_i <= op;
            operand_i <= a;
            if (op == `OPC_PUSH) begin
                ptr = ptr + 8'h01;
                ram[ptr] = a ^ key;
                exp_q.push_back({2'b00, 16'h0000, ptr});
            end else if (op == `OPC_POP) begin
                v = ram[ptr];
                ptr = ptr - 8'h01;
                if (a == `STACK_PTR_DIRECT_ADDR) ptr = v;
                exp_q.push_back({2'b01, a, v, ptr});
            end else exp_q.push_back({2'b10, 16'h0000, ptr});
            @(posedge clk_i);
            start_i <= dbl;
            if (dbl) @(posedge clk_i) start_i <= 1'b0;
            n = 0;
            do begin
                @(negedge clk_i);
                n = n + 1;
            end while (n < 8 && done_o !== 1'b1 && illegal_o !== 1'b1);
            if (done_o !== 1'b1 && illegal_o !== 1'b1) begin
                fails = fails + 1;
                report_and_stop;
            end
        end
    endtask
    initial begin
        n = $urandom(32'he960);
        key = 8'($urandom);
        ptr = `STACK_PTR_RESET;
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_i);
        chk({18'h00000, stack_top_pointer_o}, {18'h00000, ptr});
        for (i = 0; i < 6; i = i + 1) run(`OPC_PUSH, 8'($urandom), i == 2);
        for (i = 0; i < 6; i = i + 1) run(`OPC_POP, 8'h40 + i[7:0], 1'b0);
        $display("push and pop test done");
        run(`OPC_PUSH, 8'hff ^ key, 1'b0);
        run(`OPC_POP, `STACK_PTR_DIRECT_ADDR, 1'b0);
        run(`OPC_PUSH, 8'h33, 1'b0);
        run(`OPC_POP, `FLAGS_DIRECT_ADDR, 1'b0);
        run(8'h5a, 8'h12, 1'b0);
        $display("corner test done");
        report_and_stop;
    end
endmodule
bind stack_push_pop_exec stack_exec_sva i_stack_exec_sva (.*);
